/* bcs_consts.svh */
// Constants of the bus cycle sequencer.
// Included by the package, the core and the bench; definitions only.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH
// Register byte offsets
`define BCS_OFF_ADDR 8'h00
`define BCS_OFF_WDATA 8'h04
`define BCS_OFF_CMD 8'h08
`define BCS_OFF_STAT 8'h0c
`define BCS_OFF_RDATA 8'h10
`define BCS_OFF_FLAGS 8'h14
`define BCS_OFF_VECT 8'h18
// Command fields
`define BCS_CMD_CODE 2:0
`define BCS_CMD_SEG 4:3
`define BCS_CMD_WORD 5
`define BCS_CMD_POLL 6
// Flag register fields
`define BCS_FLG_IF 0
`define BCS_FLG_RET 1
// Cycle status codes
`define BCS_CS_INTERRUPT_ACK_STROBE 3'h0
`define BCS_CS_IORD 3'h1
`define BCS_CS_IOWR 3'h2
`define BCS_CS_HALT 3'h3
`define BCS_CS_FETCH 3'h4
`define BCS_CS_MRD 3'h5
`define BCS_CS_MWR 3'h6
`define BCS_CS_PASS 3'h7
// Segment codes
`define BCS_SEG_ES 2'h0
`define BCS_SEG_SS 2'h1
`define BCS_SEG_CS 2'h2
`define BCS_SEG_DS 2'h3
// Reset and interrupt numbers
`define BCS_RESET_VEC 20'hffff0
`define BCS_BOOT_CYCLES 10
`define BCS_NMI_TYPE 8'h02
`endif

/* bcs_core.sv */
// Bus cycle sequencer with reset, interrupt and halt control.
// Assumes one AHB-Lite master, single word transfers, and pins
// synchronous to CLK; the two-way data lines are resolved outside.
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bcs_consts.svh"
// Contract
// - Bus cycle is T1,T2,T3,T4, four clocks minimum
// - Address in T1, turnaround T2, data T3-T4
// - Waits between T3 and T4; idles between cycles
// - Latch strobe pulses in T1
// - Mode pin selects own strobes or status
// - Three status lines carry cycle type code
// - Extended status on upper lines T2-T4
// - Two status bits show cycle segment
// - I/O cycles drive upper lines low
// - Reset aborts; ten clocks, then fetch FFFF0
// - Vector table of 256 four-byte entries
// - Non-maskable request beats maskable request
// - Non-maskable served at instruction boundary only
// - Maskable level request served at boundary
// - Taking interrupt clears and saves enable flag
// - Lock from T2 first to T2 second
// - Type byte times four gives vector
// - Interrupt return restores saved enable flag
// - Halt left only on interrupt or reset
// - Strobes active T2 start to T4 start
// - Even bytes low lanes, odd bytes high
module bcs_core
  import bcs_pkg::*;
#(
  parameter int BOOT_CYCLES = `BCS_BOOT_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SYSTEM_MODE_SELECT,
  input wire logic READY,
  input wire logic NMI_REQUEST,
  input wire logic MASKABLE_REQUEST,
  input wire logic [15:0] AD_IN,
  output logic [15:0] AD_OUT,
  output logic AD_OE,
  output logic [3:0] ADDR_STATUS,
  output logic HIGH_BYTE_ENABLE_N,
  output logic [2:0] CYCLE_STATUS,
  output logic ALE,
  output logic MEM_IO,
  output logic RD_N,
  output logic WR_N,
  output logic INTERRUPT_ACK_STROBE_N,
  output logic DT_R,
  output logic DEN_N,
  output logic LOCK_N
);
  localparam logic [3:0] BOOT_LAST = 4'(BOOT_CYCLES - 1);

  bcs_state_type state_ff;
  bcs_state_type nxt_state;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  // One process: bus slave, sequencer and pin shaping
  always_comb begin
    bcs_state_type q;
    bcs_state_type n;
    logic busy;
    logic cmd_wr;
    logic boundary;
    logic take_nmi;
    logic take_maskable_request;
    logic is_wr;
    logic is_io;
    logic strobe;
    logic in_cyc;
    logic [31:0] rd;
    q = state_ff;
    n = state_ff;
    rd = 32'h0000_0000;
    boundary = 1'b0;
    take_nmi = 1'b0;
    take_maskable_request = 1'b0;
    is_wr = 1'b0;
    is_io = 1'b0;
    strobe = 1'b0;
    in_cyc = 1'b0;
    n.int_taken = 1'b0;
    n.min_mode = SYSTEM_MODE_SELECT;
    busy = q.go | q.ack2_pend | (q.phase != BCS_TI)
      | (q.seq != BCS_RUN);
    cmd_wr = q.bus_wr && (q.bus_addr == `BCS_OFF_CMD);

    // Rising request edge latched; a new edge wins over service
    n.nmi_prev = NMI_REQUEST;

    // Register writes land in the data phase
    if (q.bus_wr) begin
      unique case (q.bus_addr)
        `BCS_OFF_ADDR: if (!busy) n.addr = HWDATA[19:0];
        `BCS_OFF_WDATA: if (!busy) n.wdata = HWDATA[15:0];
        `BCS_OFF_FLAGS: begin
          if (HWDATA[`BCS_FLG_RET]) begin
            n.if_flag = q.saved_if;
          end else begin
            n.if_flag = HWDATA[`BCS_FLG_IF];
          end
        end
        default: ;
      endcase
    end
    if (cmd_wr && !busy && !HWDATA[`BCS_CMD_POLL]) begin
      n.code = HWDATA[`BCS_CMD_CODE];
      n.seg = HWDATA[`BCS_CMD_SEG];
      n.word = HWDATA[`BCS_CMD_WORD];
      if (HWDATA[`BCS_CMD_CODE] == `BCS_CS_HALT) begin
        n.seq = BCS_HALT;
      end else if (HWDATA[`BCS_CMD_CODE] != `BCS_CS_PASS) begin
        n.go = 1'b1;
      end
    end

    // Service only at a boundary poll or out of halt
    boundary = (cmd_wr && !busy && HWDATA[`BCS_CMD_POLL])
      || (q.seq == BCS_HALT);
    take_nmi = boundary && q.nmi_pend;
    take_maskable_request = boundary && !q.nmi_pend
      && MASKABLE_REQUEST && q.if_flag;
    if (take_nmi || take_maskable_request) begin
      n.seq = BCS_RUN;
      n.saved_if = q.if_flag;
      n.if_flag = 1'b0;
      n.int_taken = 1'b1;
    end
    if (take_nmi) begin
      n.vtype = `BCS_NMI_TYPE;
      n.vnmi = 1'b1;
    end
    if (take_maskable_request) begin
      n.code = `BCS_CS_INTERRUPT_ACK_STROBE;
      n.seg = `BCS_SEG_CS;
      n.word = 1'b0;
      n.go = 1'b1;
      n.ack2_pend = 1'b1;
      n.vnmi = 1'b0;
    end
    // Set wins over the service clear
    n.nmi_pend = (q.nmi_pend && !take_nmi)
      || (NMI_REQUEST && !q.nmi_prev);

    // Internal reset sequence, then the restart fetch
    if (q.seq == BCS_BOOT) begin
      n.boot_cnt = q.boot_cnt + 4'h1;
      if (q.boot_cnt == BOOT_LAST) begin
        n.seq = BCS_RUN;
        n.go = 1'b1;
        n.code = `BCS_CS_FETCH;
        n.seg = `BCS_SEG_CS;
        n.word = 1'b1;
        n.addr = `BCS_RESET_VEC;
      end
    end

    // Bus phase sequencing
    unique case (q.phase)
      BCS_TI, BCS_T4: begin
        if (q.ack2_pend && q.phase == BCS_T4) begin
          n.phase = BCS_T1;
          n.ack2_pend = 1'b0;
          n.ack_stage = 2'd2;
        end else if (q.go) begin
          n.phase = BCS_T1;
          n.go = 1'b0;
          n.ack_stage = q.ack2_pend ? 2'd1 : 2'd0;
        end else begin
          n.phase = BCS_TI;
          n.ack_stage = 2'd0;
        end
      end
      BCS_T1: n.phase = BCS_T2;
      BCS_T2: n.phase = BCS_T3;
      BCS_T3, BCS_TW: begin
        n.phase = READY ? BCS_T4 : BCS_TW;
        if (READY) begin
          // Odd bytes arrive on the high lanes
          if (q.word) begin
            n.rdata = AD_IN;
          end else if (q.addr[0]) begin
            n.rdata = {8'h00, AD_IN[15:8]};
          end else begin
            n.rdata = {8'h00, AD_IN[7:0]};
          end
          if (q.ack_stage == 2'd2) begin
            n.vtype = AD_IN[7:0];
          end
        end
      end
      default: n.phase = BCS_TI;
    endcase

    // Pin shaping from the next state, so pins match the phase
    is_wr = (n.code == `BCS_CS_IOWR) || (n.code == `BCS_CS_MWR);
    is_io = !n.code[2];
    in_cyc = n.phase != BCS_TI;
    strobe = (n.phase == BCS_T2) || (n.phase == BCS_T3)
      || (n.phase == BCS_TW);
    n.pins.ale = n.min_mode && (n.phase == BCS_T1);
    if (in_cyc) n.pins.mem_io = !is_io;
    n.pins.rd_n = !(n.min_mode && strobe && !is_wr
      && n.code != `BCS_CS_INTERRUPT_ACK_STROBE);
    n.pins.wr_n = !(n.min_mode && strobe && is_wr);
    n.pins.interrupt_ack_strobe_n = !(n.min_mode && strobe
      && n.code == `BCS_CS_INTERRUPT_ACK_STROBE);
    n.pins.dt_r = in_cyc ? is_wr : q.pins.dt_r;
    n.pins.den_n = !(n.min_mode && in_cyc
      && n.phase != BCS_T1);
    // Lock opens at T2 of the first acknowledge, ends at T2 of second
    if (n.phase == BCS_T2 && q.phase == BCS_T1) begin
      if (n.ack_stage == 2'd1) n.pins.lock_n = 1'b0;
      if (n.ack_stage == 2'd2) n.pins.lock_n = 1'b1;
    end
    // Status code in T1 and T2 of maximum mode, halt code while halted, passive otherwise
    if (n.seq == BCS_HALT) begin
      n.pins.cstat = `BCS_CS_HALT;
    end else if (!n.min_mode && (n.phase == BCS_T1
        || n.phase == BCS_T2)) begin
      n.pins.cstat = n.code;
    end else begin
      n.pins.cstat = `BCS_CS_PASS;
    end
    if (n.phase == BCS_T1) begin
      n.pins.ad_out = n.addr[15:0];
      n.pins.ad_oe = n.code != `BCS_CS_INTERRUPT_ACK_STROBE;
      n.pins.upper = is_io ? 4'h0 : n.addr[19:16];
      n.pins.bhe_n = !(n.word || n.addr[0]);
    end else if (in_cyc) begin
      n.pins.upper = {1'b0, n.if_flag, n.seg};
      n.pins.ad_oe = is_wr;
      if (n.word) begin
        n.pins.ad_out = n.wdata;
      end else if (n.addr[0]) begin
        n.pins.ad_out = {n.wdata[7:0], 8'h00};
      end else begin
        n.pins.ad_out = {8'h00, n.wdata[7:0]};
      end
    end else begin
      n.pins.ad_oe = 1'b0;
    end

    // Read data for the next data phase
    unique case (HADDR[7:0])
      `BCS_OFF_ADDR: rd = {12'h000, q.addr};
      `BCS_OFF_WDATA: rd = {16'h0000, q.wdata};
      `BCS_OFF_STAT: rd = {24'h000000, q.int_taken,
        q.min_mode, MASKABLE_REQUEST, q.nmi_pend,
        q.seq == BCS_BOOT, q.seq == BCS_HALT, 1'b0, busy};
      `BCS_OFF_RDATA: rd = {16'h0000, q.rdata};
      `BCS_OFF_FLAGS: rd = {30'h00000000, q.saved_if,
        q.if_flag};
      `BCS_OFF_VECT: rd = {15'h0000, q.vnmi, 6'h00,
        q.vtype, 2'b00};
      default: rd = 32'h0000_0000;
    endcase
    n.bus_wr = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      n.bus_wr = HWRITE;
      n.bus_addr = HADDR[7:0];
      n.hrdata = HWRITE ? 32'h0000_0000 : rd;
    end
    nxt_state = n;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  // Reset aborts any cycle at once and floats the lines
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_ff <= '0;
      state_ff.seq <= BCS_BOOT;
      state_ff.code <= `BCS_CS_PASS;
      state_ff.seg <= `BCS_SEG_CS;
      state_ff.pins.rd_n <= 1'b1;
      state_ff.pins.wr_n <= 1'b1;
      state_ff.pins.interrupt_ack_strobe_n <= 1'b1;
      state_ff.pins.den_n <= 1'b1;
      state_ff.pins.lock_n <= 1'b1;
      state_ff.pins.bhe_n <= 1'b1;
      state_ff.pins.mem_io <= 1'b1;
      state_ff.pins.cstat <= `BCS_CS_PASS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register
  assign HRDATA = state_ff.hrdata;
  assign HREADYOUT = 1'b1 | state_ff.bus_wr;
  assign HRESP = 1'b0 & state_ff.bus_wr;
  assign AD_OUT = state_ff.pins.ad_out;
  assign AD_OE = state_ff.pins.ad_oe;
  assign ADDR_STATUS = state_ff.pins.upper;
  assign HIGH_BYTE_ENABLE_N = state_ff.pins.bhe_n;
  assign CYCLE_STATUS = state_ff.pins.cstat;
  assign ALE = state_ff.pins.ale;
  assign MEM_IO = state_ff.pins.mem_io;
  assign RD_N = state_ff.pins.rd_n;
  assign WR_N = state_ff.pins.wr_n;
  assign INTERRUPT_ACK_STROBE_N = state_ff.pins.interrupt_ack_strobe_n;
  assign DT_R = state_ff.pins.dt_r;
  assign DEN_N = state_ff.pins.den_n;
  assign LOCK_N = state_ff.pins.lock_n;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking chk_cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_phase_order: assert property (
    state_ff.phase == BCS_T1 |=> state_ff.phase == BCS_T2
      ##1 state_ff.phase == BCS_T3)
    else $error("bus phases out of order");
  chk_wait_insert: assert property (
    state_ff.phase inside {BCS_T3, BCS_TW} && !READY
      |=> state_ff.phase == BCS_TW)
    else $error("wait state missing");
  chk_ale_in_t1: assert property (
    ALE |-> state_ff.phase == BCS_T1)
    else $error("latch strobe outside T1");
  chk_max_status: assert property (
    state_ff.phase == BCS_T1 && !state_ff.min_mode
      |-> CYCLE_STATUS == state_ff.code && RD_N && !ALE)
    else $error("bad max mode status");
  chk_ext_status: assert property (
    state_ff.phase inside {BCS_T2, BCS_T3, BCS_T4}
      |-> ADDR_STATUS == {1'b0, state_ff.if_flag, state_ff.seg})
    else $error("bad extended status");
  chk_io_upper: assert property (
    state_ff.phase == BCS_T1 && !state_ff.code[2]
      |-> ADDR_STATUS == 4'h0)
    else $error("upper lines not low on io");
  chk_boot_fetch: assert property (
    $fell(RST) |-> ##[10:11] (state_ff.phase == BCS_T1
      && AD_OUT == 16'hfff0 && ADDR_STATUS == 4'hf))
    else $error("no restart fetch");
  chk_if_cleared: assert property (
    state_ff.int_taken |-> !state_ff.if_flag
      && state_ff.saved_if == $past(state_ff.if_flag))
    else $error("enable flag not cleared");
  chk_nmi_first: assert property (
    state_ff.int_taken && $past(state_ff.nmi_pend)
      |-> state_ff.vnmi)
    else $error("maskable taken over nmi");
  chk_lock_span: assert property (
    state_ff.ack_stage == 2'd1 && state_ff.phase == BCS_T3
      |-> !LOCK_N ##2 !LOCK_N)
    else $error("lock not held");
  chk_read_strobe: assert property (
    state_ff.min_mode && state_ff.code == `BCS_CS_MRD
      && state_ff.phase == BCS_T2 |-> !RD_N && !AD_OE)
    else $error("read strobe late");
  chk_halt_hold: assert property (
    state_ff.seq == BCS_HALT && !state_ff.nmi_pend
      && !MASKABLE_REQUEST |=> state_ff.seq == BCS_HALT)
    else $error("left halt without cause");
endmodule : bcs_core
`default_nettype wire

/* bcs_core_bench.sv */
// Self-checking bench of the bus cycle sequencer.
// Assumes the far-side model answers every pin cycle.
`timescale 1ns/10ps
`default_nettype none
`include "bcs_consts.svh"
module bcs_core_bench;
  import bcs_pkg::*;
  localparam int BOOT = 10;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, mode = 1'b1;
  logic mreq = 1'b0, nmi = 1'b0, ready, ale, mem_io, rd_n, wr_n, interrupt_ack_strobe_n;
  logic dt_r, den_n, lock_n, bhe_n, ad_oe, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s;
  logic [1:0] htrans = 2'h0;
  logic [15:0] ad_in, ad_out, rd_word = 16'h0;
  logic [3:0] addr_status, waits = 4'h0;
  logic [2:0] cstat;
  int n_mismatch = 0, total_checks = 0, n, na, ni;
  always #5 clk = ~clk;
  bcs_core #(.BOOT_CYCLES(BOOT)) uut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SYSTEM_MODE_SELECT(mode),
    .READY(ready), .NMI_REQUEST(nmi), .MASKABLE_REQUEST(mreq), .AD_IN(ad_in),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .ADDR_STATUS(addr_status), .HIGH_BYTE_ENABLE_N(bhe_n),
    .CYCLE_STATUS(cstat), .ALE(ale), .MEM_IO(mem_io), .RD_N(rd_n), .WR_N(wr_n),
    .INTERRUPT_ACK_STROBE_N(interrupt_ack_strobe_n), .DT_R(dt_r), .DEN_N(den_n), .LOCK_N(lock_n));
  bcs_far_model far (.clk(clk), .rst(rst), .ale(ale), .cycle_status(cstat), .ad_oe(ad_oe),
    .ad_out(ad_out), .waits(waits), .rd_word(rd_word), .ready(ready), .ad_in(ad_in));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    s = hrdata;
  endtask : bus
  task automatic idle_wait;
    int k;
    k = 0;
    do begin
      bus(1'b0, `BCS_OFF_STAT, 32'h0);
      k++;
    end while (s[0] !== 1'b0 && k < 100);
    chk("busy and response", 32'h0, {30'h0, hresp, s[0]});
  endtask : idle_wait
  // Loads address and command, then waits for the latch strobe
  task automatic start(input logic [31:0] a, input logic [31:0] c);
    int k;
    bus(1'b1, `BCS_OFF_ADDR, a);
    bus(1'b1, `BCS_OFF_CMD, c);
    k = 0;
    do begin
      tick;
      k++;
    end while (ale !== 1'b1 && k < 20);
  endtask : start
  task automatic nmi_pulse;
    @(posedge clk) nmi <= 1'b1;
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
  endtask : nmi_pulse
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    do begin
      tick;
      n++;
    end while (ale !== 1'b1 && n < 40);
    chk("boot clocks", BOOT + 1, n);
    chk("boot address", 32'hfff0, {16'h0, ad_out});
    chk("boot upper", 32'hf, {28'h0, addr_status});
    idle_wait;
    // Word read with two wait states
    waits <= 4'h2;
    rd_word <= 16'h5a3c;
    start(32'h9a5c4, 32'h3d);
    chk("T1 lines", 32'hc000_a5c4, {ale, ad_oe, 14'h0, ad_out});
    chk("T1 upper", 32'h19, {27'h0, mem_io, addr_status});
    tick;
    chk("T2 pins", 32'h0, {den_n, rd_n, ad_oe, ale});
    chk("T2 status", 32'h3, {28'h0, addr_status});
    n = 1;
    while (rd_n === 1'b0 && n < 20) begin
      tick;
      n++;
    end
    chk("read clocks", 32'h5, n);
    idle_wait;
    bus(1'b0, `BCS_OFF_RDATA, 32'h0);
    chk("read data", 32'h5a3c, s);
    // Port write: upper lines low
    waits <= 4'h0;
    bus(1'b1, `BCS_OFF_WDATA, 32'hbeef);
    start(32'hf1234, 32'h32);
    chk("port T1", 32'h01234, {mem_io, addr_status, ad_out});
    tick;
    chk("port T2", 32'h1, {wr_n, dt_r});
    tick;
    chk("port T3", 32'h1beef, {15'h0, ad_oe, ad_out});
    idle_wait;
    // Byte fetches on both lanes
    for (int i = 0; i < 2; i++) begin
      start(32'h00100 + i, 32'h14);
      chk("high byte enable", 32'h1 - i, {31'h0, bhe_n});
      idle_wait;
    end
    // Maskable request: two acknowledge cycles
    rd_word <= 16'h0021;
    bus(1'b1, `BCS_OFF_FLAGS, 32'h1);
    @(posedge clk) mreq <= 1'b1;
    bus(1'b1, `BCS_OFF_CMD, 32'h40);
    na = 0;
    ni = 0;
    repeat (30) begin
      tick;
      if (ale === 1'b1) begin
        na++;
        if (na == 2) chk("lock", 32'h0, {31'h0, lock_n});
      end
      if (interrupt_ack_strobe_n === 1'b0) ni++;
    end
    chk("ack cycles", 32'h0002_0004, {na[15:0], ni[15:0]});
    @(posedge clk) mreq <= 1'b0;
    bus(1'b0, `BCS_OFF_VECT, 32'h0);
    chk("vector", 32'h84, s);
    bus(1'b0, `BCS_OFF_FLAGS, 32'h0);
    chk("flags taken", 32'h2, s);
    bus(1'b1, `BCS_OFF_FLAGS, 32'h2);
    bus(1'b0, `BCS_OFF_FLAGS, 32'h0);
    chk("flags return", 32'h3, s);
    // Both requests: the non-maskable one wins
    @(posedge clk) mreq <= 1'b1;
    nmi_pulse;
    bus(1'b1, `BCS_OFF_CMD, 32'h40);
    idle_wait;
    bus(1'b0, `BCS_OFF_VECT, 32'h0);
    chk("nmi vector", 32'h10008, s);
    // Halt: masked request keeps it, an nmi edge ends it
    bus(1'b1, `BCS_OFF_CMD, 32'h3);
    repeat (4) tick;
    chk("halt status", 32'h3, {29'h0, cstat});
    bus(1'b0, `BCS_OFF_STAT, 32'h0);
    chk("halted", 32'h1, {31'h0, s[2]});
    nmi_pulse;
    @(posedge clk) mreq <= 1'b0;
    bus(1'b0, `BCS_OFF_STAT, 32'h0);
    chk("halt left", 32'h0, {31'h0, s[2]});
    // Maximum mode: status codes, no own strobe
    @(posedge clk) mode <= 1'b0;
    for (int c = 1; c < 7; c++) begin
      if (c == 3) continue;
      bus(1'b1, `BCS_OFF_ADDR, 32'h00200);
      bus(1'b1, `BCS_OFF_CMD, 32'h10 | c);
      n = 0;
      do begin
        tick;
        n++;
      end while (cstat === 3'h7 && n < 20);
      chk("cycle status", c, {29'h0, cstat});
      chk("max ale", 32'h0, {31'h0, ale});
      idle_wait;
    end
    // Reset in mid-cycle aborts at once
    @(posedge clk) mode <= 1'b1;
    waits <= 4'h5;
    start(32'h00300, 32'h3d);
    tick;
    @(posedge clk) rst <= 1'b1;
    tick;
    chk("abort", 32'h27, {rd_n, ad_oe, ale, cstat});
    summarize;
  end
  initial begin
    #300000;
    n_mismatch++;
    summarize;
  end
endmodule : bcs_core_bench
`default_nettype wire

/* bcs_far_model.sv */
// Model of the memory, ports and interrupt controller beyond the pins.
// Assumes one device on the lines and a clock shared with the core.
`timescale 1ns/10ps
`default_nettype none
module bcs_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ale,
  input wire logic [2:0] cycle_status,
  input wire logic ad_oe,
  input wire logic [15:0] ad_out,
  input wire logic [3:0] waits,
  input wire logic [15:0] rd_word,
  output logic ready,
  output logic [15:0] ad_in
);
  logic [3:0] cnt;
  logic [2:0] cs_prev;
  logic [15:0] junk = 16'h5a5a;
  logic t1_seen;
  // ---------------------------------------------------------------
  // Cycle tracking
  // ---------------------------------------------------------------
  // In maximum mode the strobe is rebuilt from a fresh status code
  assign t1_seen = ale | (cycle_status != 3'h7 && cycle_status != 3'h3 && cs_prev == 3'h7);
  always @(posedge clk) begin
    cs_prev <= rst ? 3'h7 : cycle_status;
    junk <= ~junk;
    if (rst || t1_seen) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hf) begin
      cnt <= cnt + 4'h1;
    end
  end
  // Not ready for the chosen number of clocks from T3 onwards
  assign ready = (cnt >= waits + 4'h1);
  // Data or type byte only in T3..T4; echo of the core's lines while it drives, junk elsewhere so stale values never pass
  assign ad_in = ad_oe ? ad_out : ((cnt >= 4'h1 && cnt <= waits + 4'h2) ? rd_word : junk);
endmodule : bcs_far_model
`default_nettype wire

/* bcs_pkg.sv */
// Types of the bus cycle sequencer.
// Assumes bcs_consts.svh is on the include path.
`include "bcs_consts.svh"
package bcs_pkg;
  typedef enum logic [2:0] {
    BCS_TI = 3'b000,
    BCS_T1 = 3'b001,
    BCS_T2 = 3'b010,
    BCS_T3 = 3'b011,
    BCS_TW = 3'b100,
    BCS_T4 = 3'b101
  } bcs_phase_type;
  typedef enum logic [1:0] {
    BCS_RUN = 2'b00,
    BCS_BOOT = 2'b01,
    BCS_HALT = 2'b10
  } bcs_seq_type;
  typedef struct packed {
    logic ale;
    logic mem_io;
    logic rd_n;
    logic wr_n;
    logic interrupt_ack_strobe_n;
    logic dt_r;
    logic den_n;
    logic lock_n;
    logic bhe_n;
    logic [2:0] cstat;
    logic [3:0] upper;
    logic [15:0] ad_out;
    logic ad_oe;
  } bcs_pins_type;
  typedef struct packed {
    bcs_phase_type phase;
    bcs_seq_type seq;
    logic [3:0] boot_cnt;
    logic min_mode;
    logic [2:0] code;
    logic [1:0] seg;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic go;
    logic ack2_pend;
    logic [1:0] ack_stage;
    logic if_flag;
    logic saved_if;
    logic nmi_prev;
    logic nmi_pend;
    logic [7:0] vtype;
    logic vnmi;
    logic int_taken;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] hrdata;
    bcs_pins_type pins;
  } bcs_state_type;
endpackage : bcs_pkg
